// *** src/pcs_handshake.sv ***
// control word, acknowledge word, status word and custom result map of the sensor
`timescale 1ns/100ps
// What this block does
// R1 - control word: product change, teach, trigger, command
// R2 - control word written whole or coil by coil
// R3 - control bit rising raises matching acknowledge bit
// R4 - acknowledge word readable as registers or inputs
// R5 - status word bit positions fixed, rest reserved
// R6 - status word readable as registers or inputs
// R7 - unmatched reserved slot reads all zero
// R8 - unreserved sensor types never enter custom space
// R9 - slots filled in sensor execution order
// R10 - name and type id inserted when selected
// R11 - same bit meaning over registers and tables
// R12 - master writes write table, reads read table
// R13 - write table holds control, number, command
// R14 - control bit falling clears its acknowledge
module pcs_handshake #(
  parameter int NRES = 8,
  parameter int NAME_WORDS = 2,
  parameter bit HAS_CODE = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reqValid,
  input wire logic [7:0] reqFunc,
  input wire logic [15:0] reqAddr,
  input wire logic [15:0] reqData,
  output logic rspValid,
  output logic rspErr,
  output logic [15:0] rspData,
  output logic [15:0] actReq,
  input wire logic [15:0] actDone,
  output logic [15:0] ackBits,
  input wire logic stsReady,
  input wire logic stsPass,
  input wire logic stsRead,
  input wire logic stsReadyLatch,
  input wire logic [2:0] stsOutputs,
  input wire logic stsMissedTrig,
  input wire logic stsTeachErr,
  input wire logic stsSysErr,
  input wire logic stsExecErr,
  output logic [31:0] prodChangeNum,
  output logic [15:0] cmdId,
  input wire logic [6:0] wtRdAddr,
  output logic [15:0] wtRdData,
  input wire logic optName,
  input wire logic optTypeId,
  input wire logic [NRES-1:0] resvEn,
  input wire logic [NRES-1:0][3:0] resvType,
  input wire logic [NRES-1:0][6:0] resvBase,
  input wire logic [NRES-1:0][6:0] resvLen,
  input wire logic mapStart,
  input wire logic senStart,
  input wire logic [3:0] senType,
  input wire logic senValid,
  input wire logic [15:0] senWord,
  output logic mapBusy
);

  typedef struct packed {
    logic [15:0] ctl;
    logic [15:0] ack;
    logic [15:0] pend;
    logic [15:0] actReq;
    logic [15:0] sts;
    logic rspValid;
    logic rspErr;
    logic [15:0] rspData;
    logic [15:0] wtRd;
    logic [0:pcs_pkg::WT_WORDS-1][15:0] wt;
    logic [0:pcs_pkg::CUST_WORDS-1][15:0] cust;
    pcs_pkg::pcs_map_t mst;
    logic [6:0] clrIdx;
    logic [15:0][3:0] typeCnt;
    logic active;
    logic [7:0] wrPtr;
    logic [7:0] wrEnd;
    logic [7:0] strIdx;
    logic busy;
  } pcs_state_t;

  pcs_state_t s_r;
  pcs_state_t s_nxt;
  logic [15:0] ackMask;
  logic hit;
  logic [6:0] hitBase;
  logic [6:0] hitLen;

  // how many enabled reservations of the same type stand before slot k
  function automatic logic [3:0] occIdx(input int k, input logic [NRES-1:0] en,
                                        input logic [NRES-1:0][3:0] typ);
    logic [3:0] n;
    n = 4'h0;
    for (int j = 0; j < NRES; j++) begin
      if (j < k && en[j] && typ[j] == typ[k]) begin
        n = n + 4'h1;
      end
    end
    return n;
  endfunction

  // in-range test shared by the coil, discrete-input and custom-space window decodes
  function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  assign ackMask = HAS_CODE ? pcs_pkg::ACK_MASK : (pcs_pkg::ACK_MASK & ~(16'h0001 << pcs_pkg::B_CODE)); // R1

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [15:0] ctlW;
    logic [15:0] rise;
    logic [4:0] bitIdx;
    s_nxt = s_r;
    ctlW = s_r.ctl;
    rise = 16'h0000;
    bitIdx = 5'h00;
    hit = 1'b0;
    hitBase = 7'h00;
    hitLen = 7'h00;
    s_nxt.rspValid = 1'b0;
    s_nxt.rspErr = 1'b0;
    s_nxt.rspData = 16'h0000;

    // request decode, answered one cycle after it is taken
    if (reqValid) begin
      s_nxt.rspValid = 1'b1;
      case (reqFunc)
        pcs_pkg::FN_WR_REG: begin
          if (reqAddr == pcs_pkg::HR_CTL) begin
            ctlW = reqData; // R2
            s_nxt.rspData = reqData;
          end else begin
            s_nxt.rspErr = 1'b1;
          end
        end
        pcs_pkg::FN_WR_COIL: begin
          bitIdx = 5'(reqAddr - pcs_pkg::COIL_LO);
          if (inRange(reqAddr, pcs_pkg::COIL_LO, pcs_pkg::COIL_HI) &&
              (reqData == pcs_pkg::COIL_ON || reqData == pcs_pkg::COIL_OFF)) begin
            ctlW[bitIdx[3:0]] = (reqData == pcs_pkg::COIL_ON); // R2
            s_nxt.rspData = reqData;
          end else begin
            s_nxt.rspErr = 1'b1;
          end
        end
        pcs_pkg::FN_RD_COIL: begin
          bitIdx = 5'(reqAddr - pcs_pkg::COIL_LO);
          if (inRange(reqAddr, pcs_pkg::COIL_LO, pcs_pkg::COIL_HI)) begin
            s_nxt.rspData = {15'h0000, s_r.ctl[bitIdx[3:0]]};
          end else begin
            s_nxt.rspErr = 1'b1;
          end
        end
        pcs_pkg::FN_RD_DISC: begin
          bitIdx = 5'(reqAddr - pcs_pkg::DISC_LO);
          if (inRange(reqAddr, pcs_pkg::DISC_LO, pcs_pkg::DISC_HI)) begin
            s_nxt.rspData = {15'h0000, bitIdx[4] ? s_r.sts[bitIdx[3:0]] : s_r.ack[bitIdx[3:0]]}; // R4 R6
          end else begin
            s_nxt.rspErr = 1'b1;
          end
        end
        pcs_pkg::FN_RD_HOLD: begin
          if (reqAddr == pcs_pkg::HR_CTL) begin
            s_nxt.rspData = s_r.ctl;
          end else if (reqAddr == pcs_pkg::HR_ACK) begin
            s_nxt.rspData = s_r.ack; // R4
          end else if (reqAddr == pcs_pkg::HR_STS) begin
            s_nxt.rspData = s_r.sts; // R6
          end else if (inRange(reqAddr, pcs_pkg::HR_CUST_LO, pcs_pkg::HR_CUST_HI)) begin
            s_nxt.rspData = s_r.cust[7'(reqAddr - pcs_pkg::HR_CUST_LO)];
          end else begin
            s_nxt.rspErr = 1'b1;
          end
        end
        pcs_pkg::FN_RD_INPUT: begin
          if (reqAddr == pcs_pkg::IR_ACK) begin
            s_nxt.rspData = s_r.ack; // R4
          end else if (reqAddr == pcs_pkg::IR_STS) begin
            s_nxt.rspData = s_r.sts; // R6
          end else if (inRange(reqAddr, pcs_pkg::IR_CUST_LO, pcs_pkg::IR_CUST_HI)) begin
            s_nxt.rspData = s_r.cust[7'(reqAddr - pcs_pkg::IR_CUST_LO)];
          end else begin
            s_nxt.rspErr = 1'b1;
          end
        end
        pcs_pkg::FN_TBL_WR: begin
          // word 0 of the write table is the same control word as register 1
          if (reqAddr == 16'h0000) begin
            ctlW = reqData; // R11 R13
          end else if (reqAddr < 16'(pcs_pkg::WT_WORDS)) begin
            s_nxt.wt[7'(reqAddr)] = reqData; // R12 R13
          end else begin
            s_nxt.rspErr = 1'b1;
          end
        end
        pcs_pkg::FN_TBL_RD: begin
          if (reqAddr == pcs_pkg::RT_ACK) begin
            s_nxt.rspData = s_r.ack; // R11 R12
          end else if (reqAddr == pcs_pkg::RT_STS) begin
            s_nxt.rspData = s_r.sts; // R11
          end else if (reqAddr >= pcs_pkg::RT_WORDS) begin
            s_nxt.rspErr = 1'b1;
          end
        end
        default: begin
          s_nxt.rspErr = 1'b1;
        end
      endcase
    end

    // acknowledge handshake; a done in the falling cycle still sets, then clears
    s_nxt.ctl = ctlW;
    rise = ctlW & ~s_r.ctl & ackMask; // R3
    s_nxt.actReq = rise;
    s_nxt.pend = (s_r.pend | rise) & ctlW & ~(s_r.pend & actDone);
    s_nxt.ack = (s_r.ack & s_r.ctl & ctlW) | (s_r.pend & actDone & ackMask); // R3 R14

    s_nxt.sts = {stsExecErr, stsSysErr, stsTeachErr, stsMissedTrig, 4'h0, stsOutputs, 1'b0,
                 stsReadyLatch, stsRead, stsPass, stsReady}; // R5

    s_nxt.wtRd = (wtRdAddr == 7'h00) ? s_r.ctl : s_r.wt[wtRdAddr];

    // custom result map builder
    case (s_r.mst)
      pcs_pkg::MAP_IDLE: begin
        s_nxt.busy = 1'b0;
      end
      pcs_pkg::MAP_CLR: begin
        s_nxt.cust[s_r.clrIdx] = 16'h0000; // R7
        s_nxt.clrIdx = s_r.clrIdx + 7'h01;
        if (s_r.clrIdx == pcs_pkg::CUST_LAST) begin
          s_nxt.mst = pcs_pkg::MAP_RUN;
          s_nxt.busy = 1'b0;
        end
      end
      pcs_pkg::MAP_RUN: begin
        if (senStart) begin
          for (int k = 0; k < NRES; k++) begin
            if (!hit && resvEn[k] && resvType[k] == senType &&
                occIdx(k, resvEn, resvType) == s_r.typeCnt[senType]) begin
              hit = 1'b1; // R9
              hitBase = resvBase[k];
              hitLen = resvLen[k];
            end
          end
          s_nxt.typeCnt[senType] = s_r.typeCnt[senType] + 4'h1; // R9
          s_nxt.active = hit && hitLen != 7'h00; // R8
          s_nxt.strIdx = 8'h00;
          s_nxt.wrEnd = {1'b0, hitBase} + {1'b0, hitLen};
          s_nxt.wrPtr = {1'b0, hitBase};
          if (hit && hitLen != 7'h00 && optTypeId) begin
            s_nxt.cust[hitBase] = {12'h000, senType}; // R10
            s_nxt.wrPtr = {1'b0, hitBase} + 8'h01;
          end
        end else if (senValid && s_r.active) begin
          if (s_r.strIdx != 8'hFF) begin
            s_nxt.strIdx = s_r.strIdx + 8'h01;
          end
          // leading name words are dropped unless the name option is on
          if ((s_r.strIdx >= 8'(NAME_WORDS) || optName) && s_r.wrPtr < s_r.wrEnd &&
              s_r.wrPtr < 8'(pcs_pkg::CUST_WORDS)) begin
            s_nxt.cust[s_r.wrPtr[6:0]] = senWord; // R9 R10
            s_nxt.wrPtr = s_r.wrPtr + 8'h01;
          end
        end
      end
      default: begin
        s_nxt.mst = pcs_pkg::MAP_IDLE;
      end
    endcase

    // a new inspection restarts the map from all zero
    if (mapStart) begin
      s_nxt.mst = pcs_pkg::MAP_CLR; // R7
      s_nxt.clrIdx = 7'h00;
      s_nxt.typeCnt = '0;
      s_nxt.active = 1'b0;
      s_nxt.busy = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.mst <= pcs_pkg::MAP_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rspValid = s_r.rspValid;
  assign rspErr = s_r.rspErr;
  assign rspData = s_r.rspData;
  assign actReq = s_r.actReq;
  assign ackBits = s_r.ack;
  assign prodChangeNum = {s_r.wt[pcs_pkg::WT_PROD_HI[6:0]], s_r.wt[pcs_pkg::WT_PROD_LO[6:0]]};
  assign cmdId = s_r.wt[pcs_pkg::WT_CMD_ID[6:0]];
  assign wtRdData = s_r.wtRd;
  assign mapBusy = s_r.busy;

  ////////////////////////////////////////////////////////////////////////////////
  ack_cause_a: assert property (@(posedge clk_sys) disable iff (rst) // R3
    ((s_r.ack & ~$past(s_r.ack)) & ~($past(s_r.pend) & $past(actDone))) == 16'h0000)
    else $error("acknowledge rose without a pending done");

  ack_drop_a: assert property (@(posedge clk_sys) disable iff (rst) // R14
    !$past(rst) |-> (s_r.ack & ~$past(s_r.ctl) & ~$past(s_r.pend)) == 16'h0000)
    else $error("acknowledge held after control bit fell");

  ack_mask_a: assert property (@(posedge clk_sys) disable iff (rst) // R1
    (s_r.ack & ~ackMask) == 16'h0000)
    else $error("acknowledge on a reserved bit");

  req_edge_a: assert property (@(posedge clk_sys) disable iff (rst) // R3
    s_r.actReq[pcs_pkg::B_TRIG] |-> !$past(s_r.ctl[pcs_pkg::B_TRIG]) && s_r.ctl[pcs_pkg::B_TRIG])
    else $error("trigger request without a rising control bit");

  rsp_time_a: assert property (@(posedge clk_sys) disable iff (rst)
    reqValid |=> rspValid ##1 !rspValid || $past(reqValid))
    else $error("answer not one cycle after request");

  reg_write_a: assert property (@(posedge clk_sys) disable iff (rst) // R2
    reqValid && reqFunc == pcs_pkg::FN_WR_REG && reqAddr == pcs_pkg::HR_CTL |=> s_r.ctl == $past(reqData))
    else $error("control word not written");

  disc_read_a: assert property (@(posedge clk_sys) disable iff (rst) // R6
    reqValid && reqFunc == pcs_pkg::FN_RD_DISC && reqAddr == pcs_pkg::DISC_LO + 16'h0010
    |=> rspData == {15'h0000, $past(s_r.sts[0])} && !rspErr)
    else $error("status ready not seen at first status input");

  sts_resv_a: assert property (@(posedge clk_sys) disable iff (rst) // R5
    s_r.sts[11:8] == 4'h0 && !s_r.sts[4] ##1 s_r.sts[15] == $past(stsExecErr))
    else $error("status word layout wrong");

  map_skip_a: assert property (@(posedge clk_sys) disable iff (rst) // R8
    s_r.mst == pcs_pkg::MAP_RUN && senStart && !hit && !mapStart |=> !s_r.active)
    else $error("unreserved sensor accepted into map");

endmodule

// *** src/pcs_pkg.sv ***
// constants and types shared by the control/status handshake block
package pcs_pkg;

  // request function codes; the two table codes are local, not network codes
  localparam logic [7:0] FN_RD_COIL = 8'h01;
  localparam logic [7:0] FN_RD_DISC = 8'h02;
  localparam logic [7:0] FN_RD_HOLD = 8'h03;
  localparam logic [7:0] FN_RD_INPUT = 8'h04;
  localparam logic [7:0] FN_WR_COIL = 8'h05;
  localparam logic [7:0] FN_WR_REG = 8'h06;
  localparam logic [7:0] FN_TBL_WR = 8'h80;
  localparam logic [7:0] FN_TBL_RD = 8'h81;

  // register numbers as the master addresses them
  localparam logic [15:0] HR_CTL = 16'h0001;
  localparam logic [15:0] IR_ACK = 16'h0001;
  localparam logic [15:0] IR_STS = 16'h0002;
  localparam logic [15:0] HR_ACK = 16'h03E9;
  localparam logic [15:0] HR_STS = 16'h03EA;
  localparam logic [15:0] IR_CUST_LO = 16'h0038;
  localparam logic [15:0] IR_CUST_HI = 16'h00A7;
  localparam logic [15:0] HR_CUST_LO = 16'h0420;
  localparam logic [15:0] HR_CUST_HI = 16'h048F;
  localparam logic [15:0] COIL_LO = 16'h0001;
  localparam logic [15:0] COIL_HI = 16'h0010;
  localparam logic [15:0] DISC_LO = 16'h2711;
  localparam logic [15:0] DISC_HI = 16'h2730;
  localparam logic [15:0] COIL_ON = 16'hFF00;
  localparam logic [15:0] COIL_OFF = 16'h0000;

  // control bit positions
  localparam int B_PROD = 0;
  localparam int B_TEACH = 1;
  localparam int B_TRIG = 2;
  localparam int B_CODE = 3;
  localparam int B_CMD = 15;
  localparam logic [15:0] ACK_MASK = 16'h800F;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // write table and read table layout
  localparam int WT_WORDS = 108;
  localparam logic [15:0] WT_PROD_HI = 16'h0001;
  localparam logic [15:0] WT_PROD_LO = 16'h0002;
  localparam logic [15:0] WT_CMD_ID = 16'h0032;
  localparam logic [15:0] RT_ACK = 16'h0000;
  localparam logic [15:0] RT_STS = 16'h0001;
  localparam logic [15:0] RT_WORDS = 16'h00F0;

  // customizable result space
  localparam int CUST_WORDS = 112;
  localparam logic [6:0] CUST_LAST = 7'h6F;

  typedef enum logic [2:0] {
    MAP_IDLE = 3'b001,
    MAP_CLR = 3'b010,
    MAP_RUN = 3'b100
  } pcs_map_t;

endpackage

// *** tb/pcs_act_model.sv ***
// model of the action side: completes each requested control action after a delay
`timescale 1ns/100ps
module pcs_act_model #(
  parameter int DLY = 3
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [15:0] actReq,
  output logic [15:0] actDone
);
  logic [15:0] pend_r;
  logic [3:0] cnt_r;
  // requests that land while a batch waits join it, so they may finish sooner than DLY
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend_r <= 16'h0000;
      cnt_r <= 4'h0;
      actDone <= 16'h0000;
    end else if (cnt_r == 4'(DLY)) begin
      actDone <= pend_r;
      pend_r <= actReq;
      cnt_r <= 4'h0;
    end else begin
      actDone <= 16'h0000;
      pend_r <= pend_r | actReq;
      if ((pend_r | actReq) != 16'h0000) cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule

// *** tb/tb.sv ***
// self-checking bench of the control/status handshake block
`timescale 1ns/100ps
module tb;
  logic clk_sys, rst, reqValid, rspValid, rspErr, mapBusy, er;
  logic [7:0] reqFunc;
  logic [15:0] reqAddr, reqData, rspData, actReq, actDone, ackBits, cmdId, wtRdData, senWord, rd;
  logic stsReady, stsPass, stsRead, stsReadyLatch, stsMissedTrig, stsTeachErr, stsSysErr, stsExecErr;
  logic [2:0] stsOutputs;
  logic [31:0] prodChangeNum;
  logic [6:0] wtRdAddr;
  logic optName, optTypeId, mapStart, senStart, senValid;
  logic [7:0] resvEn;
  logic [7:0][3:0] resvType;
  logic [7:0][6:0] resvBase, resvLen;
  logic [3:0] senType;
  logic [15:0] ex [11];
  int failures, num_checks, i;

  pcs_handshake pcs_handshake_inst (.clk_sys, .rst, .reqValid, .reqFunc, .reqAddr, .reqData, .rspValid,
    .rspErr, .rspData, .actReq, .actDone, .ackBits, .stsReady, .stsPass, .stsRead, .stsReadyLatch,
    .stsOutputs, .stsMissedTrig, .stsTeachErr, .stsSysErr, .stsExecErr, .prodChangeNum, .cmdId,
    .wtRdAddr, .wtRdData, .optName, .optTypeId, .resvEn, .resvType, .resvBase, .resvLen, .mapStart,
    .senStart, .senType, .senValid, .senWord, .mapBusy);
  pcs_act_model pcs_act_model_inst (.clk_sys, .rst, .actReq, .actDone);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic req(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    reqValid = 1'b1;
    reqFunc = f;
    reqAddr = a;
    reqData = d;
    @(posedge clk_sys);
    #1;
    reqValid = 1'b0;
    chk("rspValid", rspValid, 1'b1);
    rd = rspData;
    er = rspErr;
  endtask

  task automatic rdk(input logic [7:0] f, input logic [15:0] a, input logic [15:0] e);
    req(f, a, 16'h0000);
    chk("rspErr", er, 1'b0);
    chk("rspData", rd, e);
  endtask

  task automatic bad(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
    req(f, a, d);
    chk("rspErr", er, 1'b1);
    chk("rspData", rd, 16'h0000);
  endtask

  // the completion delay belongs to the model, so the wait is bounded rather than exact
  task automatic ackw(input logic [15:0] e);
    for (int k = 0; k < 20 && ackBits !== e; k++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("ackBits", ackBits, e);
  endtask

  task automatic sen(input logic [3:0] t, input int n, input logic [15:0] b);
    @(posedge clk_sys);
    #1;
    senStart = 1'b1;
    senType = t;
    @(posedge clk_sys);
    #1;
    senStart = 1'b0;
    for (int k = 0; k < n; k++) begin
      senValid = 1'b1;
      senWord = b + 16'(k);
      @(posedge clk_sys);
      #1;
    end
    senValid = 1'b0;
  endtask

  // new inspection: the clear must last one cycle per custom word
  task automatic mapgo();
    int k;
    @(posedge clk_sys);
    #1;
    mapStart = 1'b1;
    @(posedge clk_sys);
    #1;
    mapStart = 1'b0;
    chk("mapBusy", mapBusy, 1'b1);
    for (k = 0; k < 200 && mapBusy !== 1'b0; k++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("mapBusy", mapBusy, 1'b0);
    chk("clearCycles", k, pcs_pkg::CUST_WORDS);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    {reqValid, reqFunc, reqAddr, reqData, mapStart, senStart, senValid, senType, senWord} = '0;
    {stsExecErr, stsSysErr, stsTeachErr, stsMissedTrig, stsOutputs} = 7'h00;
    {stsReadyLatch, stsRead, stsPass, stsReady} = 4'h0;
    wtRdAddr = 7'h00;
    optName = 1'b1;
    optTypeId = 1'b1;
    // slots: type 2 at 0 len 4, type 2 at 4 len 4, type 3 at 8 len 3
    resvEn = 8'h07;
    resvType = 32'h00000322;
    resvBase = 56'h00000000020200;
    resvLen = 56'h0000000000C204;
    ex = '{16'h0002, 16'h0011, 16'h0012, 16'h0013, 16'h0002, 16'h0021, 16'h0022, 16'h0023, 16'h0000,
      16'h0000, 16'h0000};
    repeat (4) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    rdk(pcs_pkg::FN_RD_HOLD, pcs_pkg::HR_ACK, 16'h0000);
    rdk(pcs_pkg::FN_RD_INPUT, pcs_pkg::IR_STS, 16'h0000);
    $display("test reset done");
    // all bits written: only the four defined actions may be acknowledged
    req(pcs_pkg::FN_WR_REG, pcs_pkg::HR_CTL, 16'hFFFF);
    chk("actReq", actReq, 16'h8007);
    chk("echo", rd, 16'hFFFF);
    ackw(16'h8007);
    rdk(pcs_pkg::FN_RD_INPUT, pcs_pkg::IR_ACK, 16'h8007);
    rdk(pcs_pkg::FN_RD_DISC, pcs_pkg::DISC_LO + 16'h000F, 16'h0001);
    rdk(pcs_pkg::FN_RD_DISC, pcs_pkg::DISC_LO + 16'h0003, 16'h0000);
    req(pcs_pkg::FN_WR_REG, pcs_pkg::HR_CTL, 16'h0000);
    ackw(16'h0000);
    $display("test register write done");
    req(pcs_pkg::FN_WR_COIL, pcs_pkg::COIL_LO + 16'h0002, pcs_pkg::COIL_ON);
    chk("actReq", actReq, 16'h0004);
    ackw(16'h0004);
    chk("wtRdData", wtRdData, 16'h0004);
    rdk(pcs_pkg::FN_RD_COIL, pcs_pkg::COIL_LO + 16'h0002, 16'h0001);
    bad(pcs_pkg::FN_WR_COIL, pcs_pkg::COIL_LO, 16'h1234);
    req(pcs_pkg::FN_WR_COIL, pcs_pkg::COIL_LO + 16'h0002, pcs_pkg::COIL_OFF);
    ackw(16'h0000);
    $display("test coil done");
    {stsExecErr, stsSysErr, stsTeachErr, stsMissedTrig, stsOutputs} = 7'h55;
    {stsReadyLatch, stsRead, stsPass, stsReady} = 4'hD;
    repeat (3) @(posedge clk_sys);
    #1;
    rdk(pcs_pkg::FN_RD_HOLD, pcs_pkg::HR_STS, 16'hA0AD);
    rdk(pcs_pkg::FN_RD_INPUT, pcs_pkg::IR_STS, 16'hA0AD);
    rdk(pcs_pkg::FN_RD_DISC, pcs_pkg::DISC_LO + 16'h001D, 16'h0001);
    rdk(pcs_pkg::FN_RD_DISC, pcs_pkg::DISC_LO + 16'h0014, 16'h0000);
    rdk(pcs_pkg::FN_TBL_RD, pcs_pkg::RT_STS, 16'hA0AD);
    bad(pcs_pkg::FN_RD_HOLD, 16'h0500, 16'h0000);
    $display("test status done");
    req(pcs_pkg::FN_TBL_WR, pcs_pkg::WT_PROD_HI, 16'hA5C3);
    req(pcs_pkg::FN_TBL_WR, pcs_pkg::WT_PROD_LO, 16'h1E7F);
    req(pcs_pkg::FN_TBL_WR, pcs_pkg::WT_CMD_ID, 16'h0042);
    chk("prodChangeNum", prodChangeNum, 32'hA5C31E7F);
    chk("cmdId", cmdId, 16'h0042);
    bad(pcs_pkg::FN_TBL_WR, 16'h006C, 16'h0001);
    rdk(pcs_pkg::FN_TBL_RD, 16'h00EF, 16'h0000);
    bad(pcs_pkg::FN_TBL_RD, pcs_pkg::RT_WORDS, 16'h0000);
    req(pcs_pkg::FN_TBL_WR, 16'h0000, 16'h0004);
    ackw(16'h0004);
    rdk(pcs_pkg::FN_TBL_RD, pcs_pkg::RT_ACK, 16'h0004);
    req(pcs_pkg::FN_TBL_WR, 16'h0000, 16'h0000);
    ackw(16'h0000);
    $display("test table done");
    mapgo();
    // stream carries two name words before data; the fourth type-2 word overflows its slot
    sen(4'h2, 4, 16'h0011);
    sen(4'h4, 3, 16'h0041);
    sen(4'h2, 3, 16'h0021);
    for (i = 0; i < 11; i++) rdk(pcs_pkg::FN_RD_INPUT, pcs_pkg::IR_CUST_LO + 16'(i), ex[i]);
    rdk(pcs_pkg::FN_RD_HOLD, pcs_pkg::HR_CUST_LO + 16'h0005, 16'h0021);
    $display("test custom map done");
    // both insert options off: the two name words are dropped and no type id is placed
    optName = 1'b0;
    optTypeId = 1'b0;
    mapgo();
    sen(4'h3, 4, 16'h0031);
    rdk(pcs_pkg::FN_RD_INPUT, pcs_pkg::IR_CUST_LO, 16'h0000);
    rdk(pcs_pkg::FN_RD_INPUT, pcs_pkg::IR_CUST_LO + 16'h0008, 16'h0033);
    rdk(pcs_pkg::FN_RD_INPUT, pcs_pkg::IR_CUST_LO + 16'h0009, 16'h0034);
    rdk(pcs_pkg::FN_RD_HOLD, pcs_pkg::HR_CUST_LO + 16'h000A, 16'h0000);
    $display("test options off done");
    tally_and_finish();
  end
endmodule
